/* core/deadline_watch.sv */
// Per-tag deadline watch: flags a strict-class command that ran past its limit
`timescale 1ns/1ns
module deadline_watch
  import ncq_ctl_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic stop,
  input wire logic is_write,
  input wire logic [1:0] priority_class,
  input wire logic write_strict_deadline,
  input wire logic read_strict_deadline,
  input wire logic [CNT_W-1:0] completion_time_limit,
  output logic expired
);
  logic running_r;
  logic strict_r;
  logic is_write_r;
  logic [CNT_W-1:0] count_r;

  // Class captured at issue; only isochronous deadline-dependent class is strict
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      running_r <= 1'b0;
      strict_r <= 1'b0;
      is_write_r <= 1'b0;
    end else if (stop) begin
      running_r <= 1'b0;
    end else if (start) begin
      running_r <= 1'b1;
      strict_r <= (priority_class == PRIORITY_CLASS_ISOCH); // R17 R20
      is_write_r <= is_write;
    end
  end

  // Elapsed cycles since issue, saturating
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= '0;
    end else if (start || stop) begin
      count_r <= '0;
    end else if (running_r && count_r != '1) begin
      count_r <= count_r + 1'b1;
    end
  end

  // Flags apply at check time, so a later deadline command governs pending work
  assign expired = running_r && strict_r && (count_r >= completion_time_limit)
    && (is_write_r ? write_strict_deadline : read_strict_deadline); // R15 R16 R18 R19
endmodule // deadline_watch

/* core/ncq_abort_deadline_handler.sv */
// Queued non-data command interpreter: queue abort and deadline handling
// Notes on behaviour
// R1 - Subcommand zero is abort; type bits 7:4
// R2 - Host tag in sector count 7:3
// R3 - Target tag in sector number 7:3
// R4 - Type zero cancels all outstanding commands
// R5 - Type one cancels streaming commands only
// R6 - Type two cancels non-streaming commands only
// R7 - Type three cancels the target tag only
// R8 - Subcommand one is deadline handling
// R9 - Accepted deadline command completes without error
// R10 - Success reported by Set Device Bits report
// R11 - Deadline command aborted when queuing disabled
// R12 - Target tag equal own tag aborts
// R13 - Invalid target tag aborts
// R14 - Unsupported abort type aborts
// R15 - Write flag clear lets writes overrun
// R16 - Write flag set: overrun aborts everything
// R17 - Write flag only for isochronous class
// R18 - Read flag clear lets reads overrun
// R19 - Read flag set: overrun aborts everything
// R20 - Read flag only for isochronous class
// R21 - One opcode, device/head bit6 set, bit4 clear
`timescale 1ns/1ns
module ncq_abort_deadline_handler
  import ncq_ctl_pkg::*;
#(
  parameter int QD = QDEPTH,
  parameter int CNT_W = 16,
  // Bit n set: abort type n is honoured
  parameter logic [3:0] SUPPORTED_TYPES = 4'hF
) (
  input wire logic core_clk,
  input wire logic rst_n,
  // Command strobe and block from the host-facing transport
  input wire logic cmd_valid,
  input wire cmd_block_t cmd_in,
  output logic cmd_ready,
  // Queue state from the command engine
  input wire logic ncq_enabled,
  input wire logic [QD-1:0] outstanding,
  input wire logic [QD-1:0] streaming,
  input wire logic [TAG_W-1:0] max_tag,
  // Issue/complete events for timed data commands
  input wire logic issue_valid,
  input wire logic [TAG_W-1:0] issue_tag,
  input wire logic issue_is_write,
  input wire logic [1:0] issue_priority,
  input wire logic done_valid,
  input wire logic [TAG_W-1:0] done_tag,
  input wire logic [CNT_W-1:0] completion_time_limit,
  // Cancel request to the command engine
  output logic [QD-1:0] cancel_mask,
  output logic cancel_valid,
  output logic deadline_abort_all,
  // Register-image results and completion report
  output logic [7:0] status_out,
  output logic [7:0] error_out,
  output logic write_strict_deadline,
  output logic read_strict_deadline,
  output logic sdb_valid,
  output sdb_report_t sdb_out,
  output logic abort_valid,
  input wire logic report_ready
);
  // Idle takes a command, execute judges it, report waits for the host
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_REPORT} state_t;

  // Sequencing state and registered answers
  state_t state_r;
  cmd_block_t cmd_r;
  logic [QD-1:0] cancel_mask_r;
  logic cancel_valid_r;
  logic wsd_r;
  logic rsd_r;
  logic [7:0] status_r;
  logic [7:0] error_r;
  logic sdb_valid_r;
  logic abort_valid_r;
  sdb_report_t sdb_r;
  logic deadline_abort_r;
  logic [QD-1:0] expired_vec;

  // Decoded fields, checks and per-tag strobes
  logic [3:0] sub;
  logic [3:0] abt_type;
  logic [TAG_W-1:0] own_tag;
  logic [TAG_W-1:0] tgt_tag;
  logic is_ours;
  logic type_ok;
  logic tag_bad;
  logic cmd_bad;
  logic [QD-1:0] sel_mask;
  logic take;
  logic is_abort;
  logic is_deadline;
  logic tgt_is_own;
  logic tgt_out_of_range;
  logic type_in_range;
  logic [QD-1:0] own_bit;
  logic [QD-1:0] tgt_bit;
  logic [7:0] status_img;
  logic [7:0] error_img;
  logic [QD-1:0] act_img;
  logic [QD-1:0] issue_hit;
  logic [QD-1:0] done_hit;
  logic overrun_any;

  // Field extraction from the latched block
  assign sub = cmd_r.feature[FEAT_SUB_LO +: 4];
  assign abt_type = cmd_r.feature[FEAT_TYPE_LO +: 4]; // R1
  assign own_tag = cmd_r.sector_count[TAG_FIELD_LO +: TAG_W]; // R2
  assign tgt_tag = cmd_r.sector_number[TAG_FIELD_LO +: TAG_W]; // R3

  // Subcommand decode; anything but abort and deadline handling is refused
  assign is_abort = (sub == SUB_ABORT); // R1
  assign is_deadline = (sub == SUB_DEADLINE); // R8

  // Tag decode; the target tag only matters for the selected-abort type
  assign own_bit = QD'(1) << own_tag;
  assign tgt_bit = QD'(1) << tgt_tag;
  assign tgt_is_own = (tgt_tag == own_tag); // R12
  assign tgt_out_of_range = (tgt_tag > max_tag); // R13
  assign type_in_range = (abt_type <= ABT_SELECTED); // R14

  // Opcode and device/head check for acceptance
  assign is_ours = cmd_valid && (cmd_in.command == CMD_NCQ_NONDATA)
    && cmd_in.device_head[DEVHEAD_FUA_BIT] && !cmd_in.device_head[DEVHEAD_ZERO_BIT]; // R21
  assign cmd_ready = (state_r == ST_IDLE);
  assign take = is_ours && cmd_ready; // R21

  // Abort type support and target-tag checks
  always_comb begin
    type_ok = type_in_range && SUPPORTED_TYPES[abt_type[1:0]]; // R14
    tag_bad = (abt_type == ABT_SELECTED) && (tgt_is_own || tgt_out_of_range); // R12 R13
    cmd_bad = !ncq_enabled; // R11
    if (is_abort) begin
      cmd_bad = cmd_bad || !type_ok || tag_bad;
    end else if (!is_deadline) begin
      cmd_bad = 1'b1;
    end
  end

  // Selection of commands to cancel per abort type; own tag never cancelled
  always_comb begin
    case (abt_type)
      ABT_ALL: sel_mask = outstanding; // R4
      ABT_STREAM: sel_mask = outstanding & streaming; // R5
      ABT_NONSTREAM: sel_mask = outstanding & ~streaming; // R6
      ABT_SELECTED: sel_mask = outstanding & tgt_bit; // R7
      default: sel_mask = '0;
    endcase
    sel_mask = sel_mask & ~own_bit;
  end

  // Command sequencing: latch, execute, report
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      cmd_r <= '0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (take) begin
            cmd_r <= cmd_in;
            state_r <= ST_EXEC;
          end
        end
        ST_EXEC: state_r <= ST_REPORT;
        ST_REPORT: begin
          if (report_ready) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Execution results, computed once in the execute state
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cancel_mask_r <= '0;
      cancel_valid_r <= 1'b0;
    end else begin
      cancel_valid_r <= 1'b0;
      if (state_r == ST_EXEC) begin
        if (!cmd_bad && is_abort) begin
          cancel_mask_r <= sel_mask;
          cancel_valid_r <= 1'b1;
        end else begin
          cancel_mask_r <= '0;
        end
      end
    end
  end

  // Strict-deadline flags held until the next accepted deadline command
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wsd_r <= 1'b0;
      rsd_r <= 1'b0;
    end else if (state_r == ST_EXEC && !cmd_bad && is_deadline) begin // R8
      wsd_r <= cmd_r.feature[FEAT_WSD_BIT];
      rsd_r <= cmd_r.feature[FEAT_RSD_BIT];
    end
  end

  // Answer images; abort bits sit on top of the idle ready image
  always_comb begin
    status_img = STATUS_RESET;
    error_img = ERROR_RESET; // R9
    act_img = '0;
    if (cmd_bad) begin
      status_img[STAT_ERR_BIT] = 1'b1; // R11 R12 R13 R14
      error_img[ERR_ABT_BIT] = 1'b1;
    end else begin
      // Own tag always closes; cancelled tags close in the same report
      act_img = own_bit; // R10
      if (is_abort) begin
        act_img = act_img | sel_mask;
      end
    end
  end

  // Status and error images; success carries no error bit
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_r <= STATUS_RESET;
      error_r <= ERROR_RESET;
    end else if (state_r == ST_EXEC) begin
      status_r <= status_img; // R9
      error_r <= error_img;
    end
  end

  // Completion report: pulse held until accepted downstream
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sdb_valid_r <= 1'b0;
      abort_valid_r <= 1'b0;
      sdb_r <= '0;
    end else if (state_r == ST_EXEC) begin
      sdb_valid_r <= !cmd_bad; // R10
      abort_valid_r <= cmd_bad;
      sdb_r.status <= status_img;
      sdb_r.error <= error_img;
      sdb_r.act <= act_img; // R10
    end else if (state_r == ST_REPORT && report_ready) begin
      sdb_valid_r <= 1'b0;
      abort_valid_r <= 1'b0;
    end
  end

  // One-hot issue and completion strobes, one bit per queue tag
  always_comb begin
    issue_hit = '0;
    done_hit = '0;
    if (issue_valid) begin
      issue_hit = QD'(1) << issue_tag;
    end
    if (done_valid) begin
      done_hit = QD'(1) << done_tag;
    end
  end

  // One deadline watch per queue tag
  for (genvar g = 0; g < QD; g++) begin : g_watch
    deadline_watch #(.CNT_W(CNT_W)) u_watch (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .start(issue_hit[g]),
      .stop(done_hit[g] || deadline_abort_r),
      .is_write(issue_is_write),
      .priority_class(issue_priority),
      .write_strict_deadline(wsd_r),
      .read_strict_deadline(rsd_r),
      .completion_time_limit(completion_time_limit),
      .expired(expired_vec[g])
    );
  end

  // Any strict-class watch past its limit
  assign overrun_any = |expired_vec; // R16 R19

  // Any strict overrun aborts all outstanding commands; one-cycle pulse
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      deadline_abort_r <= 1'b0;
    end else begin
      deadline_abort_r <= overrun_any && !deadline_abort_r; // R16 R19
    end
  end

  // Cancel and overrun requests toward the command engine
  assign cancel_mask = cancel_mask_r;
  assign cancel_valid = cancel_valid_r;
  assign deadline_abort_all = deadline_abort_r;

  // Answer images and report handshake, all from flip-flops
  assign status_out = status_r;
  assign error_out = error_r;
  assign write_strict_deadline = wsd_r;
  assign read_strict_deadline = rsd_r;
  assign sdb_valid = sdb_valid_r;
  assign abort_valid = abort_valid_r;
  assign sdb_out = sdb_r;
endmodule // ncq_abort_deadline_handler

/* core/ncq_ctl_pkg.sv */
// Package: command fields, encodings and status bits for the queued control-command block
package ncq_ctl_pkg;
  localparam int TAG_W = 5;
  localparam int QDEPTH = 32;
  localparam logic [7:0] CMD_NCQ_NONDATA = 8'h63;
  localparam int DEVHEAD_FUA_BIT = 6;
  localparam int DEVHEAD_ZERO_BIT = 4;
  localparam logic [3:0] SUB_ABORT = 4'h0;
  localparam logic [3:0] SUB_DEADLINE = 4'h1;
  localparam logic [3:0] ABT_ALL = 4'h0;
  localparam logic [3:0] ABT_STREAM = 4'h1;
  localparam logic [3:0] ABT_NONSTREAM = 4'h2;
  localparam logic [3:0] ABT_SELECTED = 4'h3;
  localparam int FEAT_SUB_LO = 0;
  localparam int FEAT_TYPE_LO = 4;
  localparam int FEAT_WSD_BIT = 4;
  localparam int FEAT_RSD_BIT = 5;
  localparam int TAG_FIELD_LO = 3;
  localparam logic [1:0] PRIORITY_CLASS_ISOCH = 2'h1;
  localparam int STAT_ERR_BIT = 0;
  localparam int STAT_DSC_BIT = 4;
  localparam int STAT_RDY_BIT = 6;
  localparam int ERR_ABT_BIT = 2;
  localparam logic [7:0] STATUS_RESET = 8'h50;
  localparam logic [7:0] ERROR_RESET = 8'h00;

  // Command block as presented by the host
  typedef struct packed {
    logic [7:0] feature;
    logic [7:0] sector_count;
    logic [7:0] sector_number;
    logic [7:0] device_head;
    logic [7:0] command;
  } cmd_block_t;

  // Set Device Bits report to the host
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] error;
    logic [QDEPTH-1:0] act;
  } sdb_report_t;
endpackage

/* testbench/host_cmd_model.sv */
// Host controller model: issues one queued command and acknowledges its report
`timescale 1ns/1ns
module host_cmd_model
  import ncq_ctl_pkg::*;
(
  input wire logic core_clk,
  input wire logic cmd_ready,
  input wire logic sdb_valid,
  input wire logic abort_valid,
  input wire sdb_report_t sdb_out,
  output logic cmd_valid,
  output cmd_block_t cmd_in,
  output logic report_ready
);
  initial begin
    cmd_valid = 1'b0;
    cmd_in = '0;
    report_ready = 1'b0;
  end
  // Command held until taken, then report awaited and acknowledged after a stall
  task automatic send(input cmd_block_t c, input int stall, output logic got, output sdb_report_t rep);
    got = 1'b0;
    rep = '0;
    @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd_in = c;
    while (!cmd_ready) @(negedge core_clk);
    @(negedge core_clk);
    cmd_valid = 1'b0;
    cmd_in = ~c; // Released bus shows junk, never the old command
    for (int n = 0; n < 8 && !got; n++) begin
      if (sdb_valid || abort_valid) got = 1'b1;
      else @(negedge core_clk);
    end
    rep = sdb_out;
    if (got) begin
      repeat (stall) @(negedge core_clk);
      report_ready = 1'b1;
      @(negedge core_clk);
      report_ready = 1'b0;
    end
  endtask
endmodule // host_cmd_model

/* testbench/ncq_abort_deadline_handler_asserts.sv */
// Checker: command acceptance, report timing and status codes
`timescale 1ns/1ns
module ncq_chk
  import ncq_ctl_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire cmd_block_t cmd_in,
  input wire logic cmd_ready,
  input wire logic ncq_enabled,
  input wire logic cancel_valid,
  input wire logic [7:0] status_out,
  input wire logic [7:0] error_out,
  input wire logic sdb_valid,
  input wire logic abort_valid,
  input wire logic report_ready
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Accepted command and its bounded answer
  sequence take_s;
    cmd_valid && cmd_ready && cmd_in.command == CMD_NCQ_NONDATA && cmd_in.device_head[6] && !cmd_in.device_head[4];
  endsequence
  sequence answer_s;
    ##[1:3] (sdb_valid || abort_valid);
  endsequence
  a_answer_bounded: assert property (take_s |-> answer_s) else $error("no report after command");
  a_disabled_aborts: assert property (take_s ##0 !ncq_enabled |-> ##[1:3] abort_valid) else $error("no abort");
  a_busy_after_take: assert property (take_s |=> !cmd_ready [*2]) else $error("ready too early");
  a_ignored_opcode: assert property (cmd_valid && cmd_ready && cmd_in.command != CMD_NCQ_NONDATA |=> cmd_ready)
    else $error("foreign opcode taken");
  a_report_holds: assert property ((sdb_valid || abort_valid) && !report_ready |=> $stable({sdb_valid, abort_valid}))
    else $error("report dropped");
  a_report_drops: assert property ((sdb_valid || abort_valid) && report_ready |=> !sdb_valid && !abort_valid)
    else $error("report stuck");
  a_ok_status: assert property (sdb_valid |-> status_out == 8'h50 && error_out == 8'h00 && !abort_valid)
    else $error("bad success status");
  a_abort_status: assert property (abort_valid |-> status_out == 8'h51 && error_out == 8'h04)
    else $error("bad abort status");
  a_cancel_pulse: assert property (cancel_valid |-> sdb_valid ##1 !cancel_valid) else $error("cancel too long");
endmodule // ncq_chk
bind ncq_abort_deadline_handler ncq_chk chk (.core_clk, .rst_n, .cmd_valid, .cmd_in, .cmd_ready, .ncq_enabled,
  .cancel_valid, .status_out, .error_out, .sdb_valid, .abort_valid, .report_ready);

/* testbench/ncq_abort_deadline_handler_test.sv */
// Testbench: abort types, error checks, deadline flags and overrun abort
`timescale 1ns/1ns
module ncq_abort_deadline_handler_test
  import ncq_ctl_pkg::*;
;
  logic core_clk, rst_n, cmd_valid, cmd_ready, ncq_enabled, issue_valid, issue_is_write, done_valid, got;
  logic cancel_valid, deadline_abort_all, wsd, rsd, sdb_valid, abort_valid, report_ready;
  cmd_block_t cmd_in;
  sdb_report_t sdb_out, rep;
  logic [31:0] outstanding, streaming, cancel_mask, cm_q;
  logic [4:0] max_tag, issue_tag, done_tag, own, tt;
  logic [1:0] issue_priority;
  logic [15:0] completion_time_limit;
  logic [7:0] status_out, error_out;
  int failures, check_count, dl_cnt, n;
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  ncq_abort_deadline_handler uut (.core_clk, .rst_n, .cmd_valid, .cmd_in, .cmd_ready, .ncq_enabled, .outstanding,
    .streaming, .max_tag, .issue_valid, .issue_tag, .issue_is_write, .issue_priority, .done_valid, .done_tag,
    .completion_time_limit, .cancel_mask, .cancel_valid, .deadline_abort_all, .status_out, .error_out,
    .write_strict_deadline(wsd), .read_strict_deadline(rsd), .sdb_valid, .sdb_out, .abort_valid, .report_ready);
  host_cmd_model host (.core_clk, .cmd_ready, .sdb_valid, .abort_valid, .sdb_out, .cmd_valid, .cmd_in, .report_ready);
  // Capture cancel masks and count overrun aborts
  always @(posedge core_clk) begin
    if (cancel_valid) cm_q <= cancel_mask;
    if (deadline_abort_all) dl_cnt <= dl_cnt + 1;
  end
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  function automatic cmd_block_t mk(input logic [7:0] f, input logic [4:0] tag, input logic [4:0] target_queue_tag);
    return '{f, {tag, 3'h0}, {target_queue_tag, 3'h0}, 8'h40, CMD_NCQ_NONDATA};
  endfunction
  // Expected cancel set; the abort command's own tag is never cancelled
  function automatic logic [31:0] exp_cancel(input logic [3:0] ty);
    logic [31:0] e;
    case (ty)
      ABT_ALL: e = outstanding;
      ABT_STREAM: e = outstanding & streaming;
      ABT_NONSTREAM: e = outstanding & ~streaming;
      default: e = outstanding & (32'h1 << tt);
    endcase
    return e & ~(32'h1 << own);
  endfunction
  task automatic run(input cmd_block_t c);
    host.send(c, $urandom_range(3), got, rep);
  endtask
  // Command of the given direction and class left running; expect count of overrun aborts
  task automatic overrun(input logic wr, input logic [1:0] pr, input int e);
    @(negedge core_clk);
    {issue_valid, issue_tag, issue_is_write, issue_priority} = {1'b1, 5'h02, wr, pr};
    @(negedge core_clk);
    issue_valid = 1'b0;
    n = dl_cnt;
    repeat (12) @(negedge core_clk);
    chk(dl_cnt - n, e);
    {done_valid, done_tag} = {1'b1, 5'h02};
    @(negedge core_clk);
    done_valid = 1'b0;
  endtask
  initial begin
    #2000000;
    failures++;
    summarize();
  end
  // Main sequence
  initial begin
    void'($urandom(76473));
    {rst_n, ncq_enabled, outstanding, streaming, max_tag, dl_cnt, cm_q} = {2'b01, 64'h0, 5'h1F, 64'h0};
    {issue_valid, issue_tag, issue_is_write, issue_priority, done_valid, done_tag} = '0;
    completion_time_limit = 16'h0006;
    repeat (5) @(negedge core_clk);
    rst_n = 1'b1;
    for (int k = 0; k < 8; k++) begin
      own = 5'($urandom_range(31));
      tt = own ^ 5'($urandom_range(31, 1));
      outstanding = $urandom | (32'h1 << own) | (32'h1 << tt);
      streaming = $urandom;
      run(mk({4'(k % 4), SUB_ABORT}, own, tt));
      chk({got, status_out, cm_q}, {1'b1, 8'h50, exp_cancel(4'(k % 4))});
      chk(rep, {16'h5000, exp_cancel(4'(k % 4)) | (32'h1 << own)});
    end
    $display("abort types done");
    max_tag = 5'h0F;
    run(mk({ABT_SELECTED, SUB_ABORT}, 5'h07, 5'h07));
    chk({got, status_out, error_out, rep.status, rep.error, |rep.act}, {1'b1, 32'h51045104, 1'b0});
    run(mk({ABT_SELECTED, SUB_ABORT}, 5'h03, 5'h14));
    chk({got, status_out, error_out, rep.status, rep.error, |rep.act}, {1'b1, 32'h51045104, 1'b0});
    run(mk({4'h4, SUB_ABORT}, 5'h03, 5'h01));
    chk({got, status_out, error_out, rep.status, rep.error, |rep.act}, {1'b1, 32'h51045104, 1'b0});
    ncq_enabled = 1'b0;
    run(mk(8'h31, 5'h03, 5'h00));
    chk({got, status_out, error_out, rep.status, rep.error, |rep.act}, {1'b1, 32'h51045104, 1'b0});
    run(mk({ABT_ALL, SUB_ABORT}, 5'h03, 5'h00));
    chk({got, status_out, error_out, rep.status, rep.error, |rep.act}, {1'b1, 32'h51045104, 1'b0});
    ncq_enabled = 1'b1;
    run(mk(8'h02, 5'h03, 5'h00));
    chk({got, status_out, error_out, rep.status, rep.error, |rep.act}, {1'b1, 32'h51045104, 1'b0});
    $display("error checks done");
    for (int k = 0; k < 4; k++) begin
      own = 5'($urandom_range(31));
      run(mk({2'b00, 2'(k), SUB_DEADLINE}, own, 5'h00));
      chk({got, status_out, error_out, wsd, rsd}, {1'b1, 16'h5000, k[0], k[1]});
      chk(rep, {16'h5000, 32'h1 << own});
    end
    overrun(1'b1, PRIORITY_CLASS_ISOCH, 1);
    overrun(1'b0, PRIORITY_CLASS_ISOCH, 1);
    overrun(1'b1, 2'b00, 0);
    overrun(1'b0, 2'b10, 0);
    run(mk({4'h0, SUB_DEADLINE}, 5'h04, 5'h00));
    overrun(1'b1, PRIORITY_CLASS_ISOCH, 0);
    overrun(1'b0, PRIORITY_CLASS_ISOCH, 0);
    $display("deadline done");
    run(cmd_block_t'{8'h01, 8'h08, 8'h00, 8'h40, 8'h60});
    chk(got, 1'b0);
    run(cmd_block_t'{8'h01, 8'h08, 8'h00, 8'h50, CMD_NCQ_NONDATA});
    chk(got, 1'b0);
    $display("opcode filter done");
    summarize();
  end
endmodule // ncq_abort_deadline_handler_test
